//--- src/rpdc_map.vh
// rpdc_map.vh: constants of the reset and power-down controller.
// assumes inclusion by bare name from the controller sources.
`ifndef RPDC_MAP_VH
`define RPDC_MAP_VH

// pointer byte codes
`define RPDC_PTR_RESET 8'h0f
`define RPDC_PTR_PWR 8'h0b

// software reset key, written as one 16-bit word
`define RPDC_RESET_KEY 16'h0dac

// power-down/reference register layout
`define RPDC_PWR_RST 16'h0000
`define RPDC_PWR_MASK 16'h06ff
`define RPDC_GLOBAL_POWER_DOWN_BIT 10
`define RPDC_EN_REF_BIT 9
`define RPDC_CH_LSB 0
`define RPDC_CH_MSB 7

// serial slave address, 7 bits
`define RPDC_DEV_ADDR 7'h10

// reset recovery time
`define RPDC_RECOVERY_US 100
`define RPDC_CLK_MHZ 200

// synchroniser reset values: all sampled pins idle high
`define RPDC_SYNC_RST 3'h7

`endif

//--- src/rpdc_sync.v
// rpdc_sync.v: two-flop synchroniser for a group of pin inputs.
// assumes inputs are asynchronous to clk; rst is synchronous.
`timescale 1ns/1ps
module rpdc_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // pins in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // first stage is read by the second stage only
  reg [WIDTH-1:0] meta;

  always @(posedge clk) begin
    if (rst) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // rpdc_sync

//--- src/rpdc_ctrl.v
// rpdc_ctrl.v: serial register slave with software/hardware reset and
// power-down/reference control of eight mixed-signal channels.
// assumes scl, sda and the reset pin are asynchronous pins, oversampled by
// clk; channel configuration and temperature request come from clk logic.
//
// Notes on behaviour
// - writing key 0x0dac to the reset register restores all register defaults
// - a reset returns every configurable pin to its weak pull-down default
// - software reset starts on scl fall ending the last data bit
// - no acknowledge is given for the reset key's final data byte
// - a falling edge on the reset pin triggers the same full reset
// - either reset completes within the 100 us recovery time
// - global power-down turns off reference, all DACs and the ADC
// - with global power-down clear, reference and DACs follow their bits
// - reference enable bit powers reference and buffer; clear keeps them off
// - a channel power-down bit acts only on channels configured as DAC
// - with global power-down clear, a clear channel power-down bit leaves the channel in normal mode
// - pointer code 0x0b selects the power-down/reference register
// - powered-down DAC output is three-stated, value restored on return
// - ADC powers down when no pin is configured as an ADC input and no temperature read is requested
// - with global power-down clear, a temperature read request powers the ADC up
`timescale 1ns/1ps
`include "rpdc_map.vh"
module rpdc_ctrl #(
  parameter integer RECOVERY_CYCLES = `RPDC_RECOVERY_US * `RPDC_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // serial link pins, sda open drain
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // hardware reset pin, held high in normal use
  input wire reset_pin_n,
  // channel configuration from the pin configuration logic
  input wire [7:0] dac_cfg,
  input wire [7:0] adc_cfg,
  input wire temp_read_req,
  // reset status
  output reg reset_busy,
  output reg io_default,
  // power control
  output reg ref_power_up,
  output reg [7:0] dac_power_down,
  output reg adc_power_up
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_BYTE = 5'h02;
  localparam [4:0] S_ACK = 5'h04;
  localparam [4:0] S_SEND = 5'h08;
  localparam [4:0] S_RACK = 5'h10;
  localparam [15:0] REC_LAST = RECOVERY_CYCLES[15:0] - 16'h0001;

  wire [2:0] pins_s;
  reg scl_q;
  reg sda_q;
  reg rpin_q;
  reg [4:0] state;
  reg [7:0] sh;
  reg [7:0] tx;
  reg [3:0] bitcnt;
  reg [1:0] byte_idx;
  reg rw;
  reg rd_hi;
  reg [7:0] pointer;
  reg [7:0] msb;
  reg [15:0] pwr_reg;
  reg [15:0] rec_cnt;
  wire [15:0] rx_word;
  wire [7:0] next_dac_pd;
  wire scl_s;
  wire sda_s;
  wire rpin_s;
  wire scl_rise;
  wire scl_fall;
  wire start_c;
  wire stop_c;
  wire byte_done;
  wire sw_trig;
  wire hw_trig;
  wire global_power_down;

  rpdc_sync #(
    .WIDTH(3),
    .RESET_VAL(`RPDC_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({reset_pin_n, sda_in, scl}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign rpin_s = pins_s[2];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
  assign byte_done = (state == S_BYTE) & scl_fall & (bitcnt == 4'h8);
  assign rx_word = {msb, sh};
  // the trigger point is the fall that closes bit eight of the lsb byte
  assign sw_trig = byte_done & ~rw & (byte_idx == 2'h3) &
    (pointer == `RPDC_PTR_RESET) & (rx_word == `RPDC_RESET_KEY);
  assign hw_trig = rpin_q & ~rpin_s;
  assign global_power_down = pwr_reg[`RPDC_GLOBAL_POWER_DOWN_BIT];

  // channel bits only matter where the channel is a DAC
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ch
      assign next_dac_pd[i] = dac_cfg[i] &
        (global_power_down | pwr_reg[`RPDC_CH_LSB + i]);
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rpin_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      rpin_q <= rpin_s;
    end
  end

  // reset recovery: link ignored and defaults held until the count ends
  always @(posedge clk) begin
    if (rst) begin
      reset_busy <= 1'b0;
      io_default <= 1'b1;
      rec_cnt <= 16'h0000;
    end else if (sw_trig | hw_trig) begin
      reset_busy <= 1'b1;
      io_default <= 1'b1;
      rec_cnt <= 16'h0000;
    end else if (reset_busy) begin
      if (rec_cnt == REC_LAST) begin
        reset_busy <= 1'b0;
        io_default <= 1'b0;
      end
      rec_cnt <= rec_cnt + 16'h0001;
    end else begin
      io_default <= 1'b0;
    end
  end

  // serial slave and register file
  always @(posedge clk) begin
    if (rst | sw_trig | hw_trig | reset_busy) begin
      // a host obeying the idle-scl window loses nothing here
      state <= S_IDLE;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      sh <= 8'h00;
      tx <= 8'h00;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
      rw <= 1'b0;
      rd_hi <= 1'b1;
      pointer <= 8'h00;
      msb <= 8'h00;
      pwr_reg <= `RPDC_PWR_RST;
    end else if (start_c) begin
      state <= S_BYTE;
      sda_oe <= 1'b0;
      bitcnt <= 4'h0;
      byte_idx <= 2'h0;
    end else if (stop_c) begin
      state <= S_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          sda_oe <= 1'b0;
        end
        S_BYTE: begin
          if (scl_rise && bitcnt != 4'h8) begin
            sh <= {sh[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_done) begin
            if (byte_idx == 2'h0) begin
              if (sh[7:1] == `RPDC_DEV_ADDR) begin
                rw <= sh[0];
                rd_hi <= 1'b1;
                sda_oe <= 1'b1;
                state <= S_ACK;
              end else begin
                state <= S_IDLE;
              end
            end else begin
              if (byte_idx == 2'h1) begin
                pointer <= sh;
              end else if (byte_idx == 2'h2) begin
                msb <= sh;
              end else if (pointer == `RPDC_PTR_PWR) begin
                // reserved bits are kept at zero whatever is written
                pwr_reg <= rx_word & `RPDC_PWR_MASK;
              end
              sda_oe <= 1'b1;
              state <= S_ACK;
            end
            if (byte_idx != 2'h3) begin
              byte_idx <= byte_idx + 2'h1;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              sda_oe <= ~pwr_reg[15];
              tx <= {pwr_reg[14:8], 1'b0};
              bitcnt <= 4'h1;
              rd_hi <= 1'b0;
              state <= S_SEND;
            end else begin
              bitcnt <= 4'h0;
              sda_oe <= 1'b0;
              state <= S_BYTE;
            end
          end
        end
        S_SEND: begin
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              sda_oe <= 1'b0;
              state <= S_RACK;
            end else begin
              sda_oe <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise && sda_s) begin
            state <= S_IDLE;
          end else if (scl_fall) begin
            if (rd_hi) begin
              sda_oe <= ~pwr_reg[15];
              tx <= {pwr_reg[14:8], 1'b0};
            end else begin
              sda_oe <= ~pwr_reg[7];
              tx <= {pwr_reg[6:0], 1'b0};
            end
            rd_hi <= ~rd_hi;
            bitcnt <= 4'h1;
            state <= S_SEND;
          end
        end
        default: begin
          state <= S_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // power outputs; DAC output value is held by the DAC itself while off
  always @(posedge clk) begin
    if (rst) begin
      ref_power_up <= 1'b0;
      dac_power_down <= 8'h00;
      adc_power_up <= 1'b0;
    end else begin
      ref_power_up <= ~global_power_down & pwr_reg[`RPDC_EN_REF_BIT];
      dac_power_down <= next_dac_pd;
      adc_power_up <= ~global_power_down & ((|adc_cfg) | temp_read_req);
    end
  end

endmodule // rpdc_ctrl

//--- test/rpdc_ctrl_props.sv
// rpdc_ctrl_props.sv: port checks of the reset/power controller.
// assumes a bind onto rpdc_ctrl; rst synchronous, active high.
`timescale 1ns/1ps
module rpdc_ctrl_props #(
  parameter integer RECOVERY_CYCLES = 20000
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // watched ports
  input logic sda_oe,
  input logic reset_pin_n,
  input logic [7:0] dac_cfg,
  input logic [7:0] adc_cfg,
  input logic temp_read_req,
  input logic reset_busy,
  input logic io_default,
  input logic ref_power_up,
  input logic [7:0] dac_power_down,
  input logic adc_power_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  integer busy_cnt;
  always @(posedge clk) begin
    if (rst || !reset_busy) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  chk_recover_len: assert property (
    $fell(reset_busy) |-> busy_cnt == RECOVERY_CYCLES)
    else $error("recovery length off");
  chk_pins_dflt: assert property (reset_busy |-> io_default)
    else $error("pins left configured in reset");
  // power outputs trail the register file by one edge
  chk_busy_regs: assert property (
    reset_busy && $past(reset_busy) |->
    !ref_power_up && dac_power_down == 8'h00)
    else $error("power state kept in reset");
  chk_busy_quiet: assert property (reset_busy |-> !sda_oe)
    else $error("bus driven in reset");
  chk_hw_trigger: assert property (
    $fell(reset_pin_n) |-> ##[2:6] reset_busy)
    else $error("reset pin edge missed");
  chk_dac_only: assert property (
    (dac_power_down & ~$past(dac_cfg)) == 8'h00)
    else $error("non-dac channel powered down");
  chk_adc_idle: assert property (
    $past(adc_cfg) == 8'h00 && !$past(temp_read_req) |-> !adc_power_up)
    else $error("adc on with no user");
  chk_adc_temp: assert property (
    ref_power_up && $past(temp_read_req) |-> adc_power_up)
    else $error("adc off during temperature read");
  cover property ($rose(reset_busy));
  cover property (ref_power_up && adc_power_up);
  cover property (dac_power_down != 8'h00);
endmodule // rpdc_ctrl_props

//--- test/rpdc_host.sv
// rpdc_host.sv: serial bus master model driving scl and an open-drain sda.
// assumes the bench forms the pulled-up sda level from all drivers.
`timescale 1ns/1ps
module rpdc_host (
  // clock
  input logic clk,
  // bus
  input logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // 80 ns bit; data moves mid-low so it never races the scl edges
  task bitx(input logic lo, output logic s);
    scl = 1'b0;
    wt(4);
    sda_low = lo;
    wt(4);
    scl = 1'b1;
    wt(8);
    s = sda;
  endtask
  task start;
    sda_low = 1'b1;
    wt(8);
  endtask
  task stop;
    logic s;
    bitx(1'b1, s);
    sda_low = 1'b0;
    wt(8);
  endtask
  task xfer(input logic [7:0] d, input logic ma, output logic [7:0] r,
            output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(~d[i], r[i]);
    bitx(ma, s);
    ack = ~s;
  endtask
endmodule // rpdc_host

//--- test/rpdc_ctrl_bench.sv
// rpdc_ctrl_bench.sv: self-checking bench of the reset/power controller.
// assumes rpdc_host as bus master and a 200 MHz clock.
`timescale 1ns/1ps
`include "rpdc_map.vh"
module rpdc_ctrl_bench;
  localparam integer REC = 200;
  logic clk = 1'b0;
  logic rst, reset_pin_n, temp_read_req, scl, sda_low, sda_oe, sda_out, a;
  logic reset_busy, io_default, ref_power_up, adc_power_up;
  logic [7:0] dac_cfg, adc_cfg, dac_power_down;
  logic [15:0] m, r;
  integer failures = 0, n_checks = 0, seed, k;
  wire sda = ~(sda_low | sda_oe);
  always #2.5 clk = ~clk;
  rpdc_host h (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  rpdc_ctrl #(.RECOVERY_CYCLES(REC)) DUT (.clk(clk), .rst(rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .reset_pin_n(reset_pin_n), .dac_cfg(dac_cfg), .adc_cfg(adc_cfg),
    .temp_read_req(temp_read_req), .reset_busy(reset_busy),
    .io_default(io_default), .ref_power_up(ref_power_up),
    .dac_power_down(dac_power_down), .adc_power_up(adc_power_up));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] p, input logic [15:0] v);
    logic [7:0] x;
    h.start;
    h.xfer({`RPDC_DEV_ADDR, 1'b0}, 1'b0, x, a);
    h.xfer(p, 1'b0, x, a);
    h.xfer(v[15:8], 1'b0, x, a);
    h.xfer(v[7:0], 1'b0, x, a);
    // after the key scl must stay still, so no stop is sent
    if (p != `RPDC_PTR_RESET || v != `RPDC_RESET_KEY) h.stop;
  endtask
  task rd;
    logic x;
    h.start;
    h.xfer({`RPDC_DEV_ADDR, 1'b1}, 1'b0, r[15:8], x);
    h.xfer(8'hff, 1'b1, r[15:8], x);
    h.xfer(8'hff, 1'b0, r[7:0], x);
    h.stop;
  endtask
  task ck_out;
    logic pa;
    repeat (4) @(posedge clk);
    #1;
    pa = m[10];
    chk({ref_power_up, adc_power_up, dac_power_down},
      {~pa & m[9], ~pa & (|adc_cfg | temp_read_req),
       dac_cfg & ({8{pa}} | m[7:0])});
  endtask
  task wt_busy(input logic v, input integer lim);
    integer n;
    n = 0;
    while (reset_busy !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(reset_busy, v);
  endtask
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    dac_cfg = 8'h00;
    adc_cfg = 8'h00;
    temp_read_req = 1'b0;
    seed = $urandom(32'h3fac);
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    m = `RPDC_PWR_RST;
    ck_out;
    chk(io_default, 1'b0);
    for (k = 0; k < 6; k++) begin
      m = 16'($urandom) & `RPDC_PWR_MASK;
      m[10] = k[0];
      m[9] = ~k[0];
      dac_cfg = 8'($urandom);
      adc_cfg = (k < 3) ? 8'h00 : 8'($urandom);
      temp_read_req = (k == 2);
      wr(`RPDC_PTR_PWR, m);
      chk(a, 1'b1);
      ck_out;
      rd;
      chk(r, m);
    end
    wr(`RPDC_PTR_RESET, 16'h0dab);
    chk({a, reset_busy}, 2'b10);
    ck_out;
    wr(`RPDC_PTR_RESET, `RPDC_RESET_KEY);
    chk(a, 1'b0);
    chk(sda_out, 1'b0);
    chk({reset_busy, io_default}, 2'b11);
    m = `RPDC_PWR_RST;
    wt_busy(1'b0, REC + 10);
    ck_out;
    m = 16'h02ff;
    wr(`RPDC_PTR_PWR, m);
    reset_pin_n = 1'b0;
    wt_busy(1'b1, 10);
    reset_pin_n = 1'b1;
    m = `RPDC_PWR_RST;
    wt_busy(1'b0, REC + 10);
    ck_out;
    close_out;
  end
  initial begin
    #300000;
    failures++;
    close_out;
  end
endmodule // rpdc_ctrl_bench
bind rpdc_ctrl rpdc_ctrl_props #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_props (
  .clk(clk), .rst(rst), .sda_oe(sda_oe), .reset_pin_n(reset_pin_n),
  .dac_cfg(dac_cfg), .adc_cfg(adc_cfg), .temp_read_req(temp_read_req),
  .reset_busy(reset_busy), .io_default(io_default),
  .ref_power_up(ref_power_up), .dac_power_down(dac_power_down),
  .adc_power_up(adc_power_up));
